// *** src/art_consts.vh ***
// Register offsets, control bit positions, reset values and timing counts of the timers.
`ifndef ART_CONSTS_VH
`define ART_CONSTS_VH

// Register offsets on the special function register port.
`define ART_T1_COUNT_LO  8'h8B
`define ART_T0_COUNT_HI  8'h8C
`define ART_T1_COUNT_HI  8'h8D
`define ART_T3_CONTROL   8'h91
`define ART_T3_RELOAD_LO 8'h92
`define ART_T3_RELOAD_HI 8'h93
`define ART_T3_COUNT_LO  8'h94
`define ART_T3_COUNT_HI  8'h95
`define ART_T2_CONTROL   8'hC8
`define ART_T2_RELOAD_LO 8'hCA
`define ART_T2_RELOAD_HI 8'hCB
`define ART_T2_COUNT_LO  8'hCC
`define ART_T2_COUNT_HI  8'hCD

// Control register bit positions, shared by both timers.
`define ART_HIGH_FLAG_BIT  7
`define ART_LOW_FLAG_BIT   6
`define ART_LOW_IRQ_EN_BIT 5
`define ART_CAP_EN_BIT     4
`define ART_SPLIT_BIT      3
`define ART_RUN_BIT        2
`define ART_SRC_MSB        1
`define ART_SRC_LSB        0

// Reset value of every register and the wrap limits of the counters.
`define ART_RESET_BYTE 8'h00
`define ART_BYTE_MAX   8'hFF

// Source field encodings.
`define ART_SRC_0 2'h0
`define ART_SRC_1 2'h1
`define ART_SRC_2 2'h2
`define ART_SRC_3 2'h3

// System clock divider for the divided-by-12 timebase.
`define ART_SYS_DIV       12
`define ART_SYS_DIV_LAST  4'hB

`endif

// *** src/art_sync_edge.v ***
// Two-flop synchroniser with rising-edge pulse for an external timer source.
`timescale 1ns/1ps
`default_nettype none

module art_sync_edge
(
  // Clock and reset.
  input  wire clk,
  input  wire sys_rst,
  // Asynchronous source and its synchronised rising edge.
  input  wire src_async,
  output reg  rise_r
);

  reg meta_r;
  reg sync_r;
  reg last_r;

  // Only the second flop reads the first; the edge is taken after it.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_r <= 1'b0;
    end
    else
    begin
      meta_r <= src_async;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_r <= sync_r & ~last_r;
    end
  end

endmodule

`default_nettype wire

// *** src/art_div12.v ***
// Divider that makes a one-cycle enable pulse once every twelve system clocks.
`timescale 1ns/1ps
`default_nettype none
`include "art_consts.vh"

module art_div12
(
  // Clock and reset.
  input  wire clk,
  input  wire sys_rst,
  // One-cycle enable at one twelfth of the clock rate.
  output reg  tick_r
);

  reg [3:0] cnt_r;

  // Counts 0 to 11 and pulses in the cycle after the last count.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_r  <= 4'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (cnt_r == `ART_SYS_DIV_LAST);
      if (cnt_r == `ART_SYS_DIV_LAST)
        cnt_r <= 4'h0;
      else
        cnt_r <= cnt_r + 4'h1;
    end
  end

endmodule

`default_nettype wire

// *** src/art_timers.v ***
// Second and third auto-reload/capture timers with count bytes of the zeroth and first timers.
`timescale 1ns/1ps
`default_nettype none
`include "art_consts.vh"

module art_timers
(
  // Clock and reset.
  input  wire       clk,
  input  wire       sys_rst,
  // Special function register port.
  input  wire [7:0] sfr_addr,
  input  wire       sfr_wr,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata_r,
  // Per-byte clock selects and timer interrupt enables.
  input  wire       t2_high_clock_select,
  input  wire       t2_low_clock_select,
  input  wire       t3_high_clock_select,
  input  wire       t3_low_clock_select,
  input  wire       t2_irq_enable,
  input  wire       t3_irq_enable,
  // External clock and capture sources.
  input  wire       comparator0,
  input  wire       comparator1,
  input  wire       rtc_div8,
  input  wire       external_oscillator_div8,
  // Interrupt requests.
  output reg        t2_irq_r,
  output reg        t3_irq_r
);

  // Count bytes of the zeroth and first timers.
  reg [7:0] t1_count_lo_r;
  reg [7:0] t0_count_hi_r;
  reg [7:0] t1_count_hi_r;

  // Synchronised source edges and the divided system clock.
  wire      cmp0_rise;
  wire      cmp1_rise;
  wire      rtc_rise;
  wire      osc_rise;
  wire      div12_tick;

  // Per-byte clock selects and interrupt enables, indexed by timer.
  wire [1:0] high_sel;
  wire [1:0] low_sel;
  wire [1:0] irq_en;

  assign high_sel = {t3_high_clock_select, t2_high_clock_select};
  assign low_sel  = {t3_low_clock_select, t2_low_clock_select};
  assign irq_en   = {t3_irq_enable, t2_irq_enable};

  // Every outside source passes a two-flop synchroniser first.
  art_sync_edge u_sync_cmp0
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .src_async (comparator0),
    .rise_r    (cmp0_rise)
  );

  art_sync_edge u_sync_cmp1
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .src_async (comparator1),
    .rise_r    (cmp1_rise)
  );

  art_sync_edge u_sync_rtc
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .src_async (rtc_div8),
    .rise_r    (rtc_rise)
  );

  art_sync_edge u_sync_osc
  (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .src_async (external_oscillator_div8),
    .rise_r    (osc_rise)
  );

  // The divide-by-12 timebase is an enable pulse, not a second clock.
  art_div12 u_div12
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick_r  (div12_tick)
  );

  // Both timers share one structure; index 0 is the second timer, 1 the third.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : tmr
      reg  [7:0] ctl_r;
      reg  [7:0] rl_lo_r;
      reg  [7:0] rl_hi_r;
      reg  [7:0] cnt_lo_r;
      reg  [7:0] cnt_hi_r;
      reg        irq_r;
      reg  [7:0] ctl_nxt;
      reg  [7:0] cnt_lo_nxt;
      reg  [7:0] cnt_hi_nxt;
      reg  [7:0] rl_lo_nxt;
      reg  [7:0] rl_hi_nxt;
      reg        lo_tick;
      reg        hi_tick;
      reg        set_hi;
      reg        set_lo;
      wire       wr_ctl;
      wire       wr_rll;
      wire       wr_rlh;
      wire       wr_cl;
      wire       wr_ch;
      wire       split;
      wire       run;
      wire       cap_en;
      wire       byte_clk_lo;
      wire       byte_clk_hi;
      wire       src_a;
      wire       src_b;
      wire       ext_tick;
      wire       cap_tick;

      assign wr_ctl = sfr_wr & (sfr_addr == ((i == 0) ? `ART_T2_CONTROL : `ART_T3_CONTROL));
      assign wr_rll = sfr_wr & (sfr_addr == ((i == 0) ? `ART_T2_RELOAD_LO : `ART_T3_RELOAD_LO));
      assign wr_rlh = sfr_wr & (sfr_addr == ((i == 0) ? `ART_T2_RELOAD_HI : `ART_T3_RELOAD_HI));
      assign wr_cl  = sfr_wr & (sfr_addr == ((i == 0) ? `ART_T2_COUNT_LO : `ART_T3_COUNT_LO));
      assign wr_ch  = sfr_wr & (sfr_addr == ((i == 0) ? `ART_T2_COUNT_HI : `ART_T3_COUNT_HI));
      assign split  = ctl_r[`ART_SPLIT_BIT];
      assign run    = ctl_r[`ART_RUN_BIT];
      assign cap_en = ctl_r[`ART_CAP_EN_BIT];

      // Both source tables share one shape, so decoding stays local to each timer.
      // Clock is div12, A, div12, B and capture is B, B, A, A for codes 0 to 3.
      assign src_a    = (i == 0) ? cmp0_rise : osc_rise;
      assign src_b    = (i == 0) ? rtc_rise : cmp1_rise;
      assign ext_tick = ctl_r[`ART_SRC_LSB] ? (ctl_r[`ART_SRC_MSB] ? src_b : src_a) : div12_tick;
      assign cap_tick = ctl_r[`ART_SRC_MSB] ? src_a : src_b;

      // Each byte takes the external tick on select 0, every clock on select 1.
      assign byte_clk_lo = low_sel[i] | ext_tick;
      assign byte_clk_hi = high_sel[i] | ext_tick;

      // Counting, reload, capture and flag setting for one timer.
      always @*
      begin
        cnt_lo_nxt = cnt_lo_r;
        cnt_hi_nxt = cnt_hi_r;
        rl_lo_nxt  = rl_lo_r;
        rl_hi_nxt  = rl_hi_r;
        set_hi     = 1'b0;
        set_lo     = 1'b0;
        lo_tick    = 1'b0;
        hi_tick    = 1'b0;
        if (split)
        begin
          // Low byte always counts in split mode; run gates the high byte.
          lo_tick = byte_clk_lo;
          hi_tick = run & byte_clk_hi;
          if (lo_tick)
          begin
            if (cnt_lo_r == `ART_BYTE_MAX)
            begin
              cnt_lo_nxt = rl_lo_r;
              set_lo     = 1'b1;
            end
            else
              cnt_lo_nxt = cnt_lo_r + 8'h01;
          end
          if (hi_tick)
          begin
            if (cnt_hi_r == `ART_BYTE_MAX)
            begin
              cnt_hi_nxt = rl_hi_r;
              set_hi     = 1'b1;
            end
            else
              cnt_hi_nxt = cnt_hi_r + 8'h01;
          end
        end
        else
        begin
          // One 16-bit counter clocked by the low byte select and gated by run.
          lo_tick = run & byte_clk_lo;
          if (lo_tick)
          begin
            if (cnt_lo_r == `ART_BYTE_MAX)
            begin
              set_lo = 1'b1;
              if (cnt_hi_r == `ART_BYTE_MAX)
              begin
                set_hi = 1'b1;
                // Capture mode wraps to zero since the reload bytes hold captures.
                cnt_lo_nxt = cap_en ? `ART_RESET_BYTE : rl_lo_r;
                cnt_hi_nxt = cap_en ? `ART_RESET_BYTE : rl_hi_r;
              end
              else
              begin
                cnt_lo_nxt = `ART_RESET_BYTE;
                cnt_hi_nxt = cnt_hi_r + 8'h01;
              end
            end
            else
              cnt_lo_nxt = cnt_lo_r + 8'h01;
          end
        end
        // Software writes to count or reload bytes win over counting.
        if (wr_cl)
          cnt_lo_nxt = sfr_wdata;
        if (wr_ch)
          cnt_hi_nxt = sfr_wdata;
        if (wr_rll)
          rl_lo_nxt = sfr_wdata;
        if (wr_rlh)
          rl_hi_nxt = sfr_wdata;
        // A capture event copies the live count and raises the high flag.
        if (cap_en & cap_tick)
        begin
          rl_lo_nxt = cnt_lo_r;
          rl_hi_nxt = cnt_hi_r;
          set_hi    = 1'b1;
        end
        // A hardware set wins over a software clear in the same cycle.
        ctl_nxt = wr_ctl ? sfr_wdata : ctl_r;
        if (set_hi)
          ctl_nxt[`ART_HIGH_FLAG_BIT] = 1'b1;
        if (set_lo)
          ctl_nxt[`ART_LOW_FLAG_BIT] = 1'b1;
      end

      // Timer state registers.
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          ctl_r    <= `ART_RESET_BYTE;
          rl_lo_r  <= `ART_RESET_BYTE;
          rl_hi_r  <= `ART_RESET_BYTE;
          cnt_lo_r <= `ART_RESET_BYTE;
          cnt_hi_r <= `ART_RESET_BYTE;
          irq_r    <= 1'b0;
        end
        else
        begin
          ctl_r    <= ctl_nxt;
          rl_lo_r  <= rl_lo_nxt;
          rl_hi_r  <= rl_hi_nxt;
          cnt_lo_r <= cnt_lo_nxt;
          cnt_hi_r <= cnt_hi_nxt;
          // Request follows irq_en and the high flag or enabled low flag, so with irq_en up it stays until software clears them.
          irq_r    <= irq_en[i] & (ctl_r[`ART_HIGH_FLAG_BIT] |
                      (ctl_r[`ART_LOW_IRQ_EN_BIT] & ctl_r[`ART_LOW_FLAG_BIT]));
        end
      end
    end
  endgenerate

  // Interrupt outputs come straight from the timer flops above, one cycle behind the flags.
  always @*
  begin
    t2_irq_r = tmr[0].irq_r;
    t3_irq_r = tmr[1].irq_r;
  end

  // Zeroth and first timer count bytes: storage only, their counting lives elsewhere.
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      t1_count_lo_r <= `ART_RESET_BYTE;
      t0_count_hi_r <= `ART_RESET_BYTE;
      t1_count_hi_r <= `ART_RESET_BYTE;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == `ART_T1_COUNT_LO)
        t1_count_lo_r <= sfr_wdata;
      else if (sfr_addr == `ART_T0_COUNT_HI)
        t0_count_hi_r <= sfr_wdata;
      else if (sfr_addr == `ART_T1_COUNT_HI)
        t1_count_hi_r <= sfr_wdata;
    end
  end

  // Registered read mux; unmapped addresses read as zero.
  always @(posedge clk)
  begin
    if (sys_rst)
      sfr_rdata_r <= `ART_RESET_BYTE;
    else if (sfr_addr == `ART_T1_COUNT_LO)
      sfr_rdata_r <= t1_count_lo_r;
    else if (sfr_addr == `ART_T0_COUNT_HI)
      sfr_rdata_r <= t0_count_hi_r;
    else if (sfr_addr == `ART_T1_COUNT_HI)
      sfr_rdata_r <= t1_count_hi_r;
    else if (sfr_addr == `ART_T2_CONTROL)
      sfr_rdata_r <= tmr[0].ctl_r;
    else if (sfr_addr == `ART_T2_RELOAD_LO)
      sfr_rdata_r <= tmr[0].rl_lo_r;
    else if (sfr_addr == `ART_T2_RELOAD_HI)
      sfr_rdata_r <= tmr[0].rl_hi_r;
    else if (sfr_addr == `ART_T2_COUNT_LO)
      sfr_rdata_r <= tmr[0].cnt_lo_r;
    else if (sfr_addr == `ART_T2_COUNT_HI)
      sfr_rdata_r <= tmr[0].cnt_hi_r;
    else if (sfr_addr == `ART_T3_CONTROL)
      sfr_rdata_r <= tmr[1].ctl_r;
    else if (sfr_addr == `ART_T3_RELOAD_LO)
      sfr_rdata_r <= tmr[1].rl_lo_r;
    else if (sfr_addr == `ART_T3_RELOAD_HI)
      sfr_rdata_r <= tmr[1].rl_hi_r;
    else if (sfr_addr == `ART_T3_COUNT_LO)
      sfr_rdata_r <= tmr[1].cnt_lo_r;
    else if (sfr_addr == `ART_T3_COUNT_HI)
      sfr_rdata_r <= tmr[1].cnt_hi_r;
    else
      sfr_rdata_r <= `ART_RESET_BYTE;
  end

endmodule

`default_nettype wire

// *** bench/art_timers_assertions.sv ***
// Port-level checker for the auto-reload and capture timers.
`timescale 1ns/1ps
`default_nettype none

module art_timers_chk
(
  // Clock and reset.
  input wire       clk,
  input wire       sys_rst,
  // Register port.
  input wire [7:0] sfr_addr,
  input wire       sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata_r,
  // Interrupt enables and requests.
  input wire       t2_irq_enable,
  input wire       t3_irq_enable,
  input wire       t2_irq_r,
  input wire       t3_irq_r
);
  // Decode of the map; reads elsewhere must come back as zero.
  wire plain  = sfr_addr >= 8'h8B && sfr_addr <= 8'h8D;
  wire t3_blk = sfr_addr >= 8'h91 && sfr_addr <= 8'h95;
  wire t2_blk = sfr_addr == 8'hC8 || (sfr_addr >= 8'hCA && sfr_addr <= 8'hCD);
  wire mapped = plain || t3_blk || t2_blk;
  wire c2w    = sfr_wr && sfr_addr == 8'hC8;
  wire c3w    = sfr_wr && sfr_addr == 8'h91;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RST_OUT: assert property (disable iff (1'b0) sys_rst |=>
    sfr_rdata_r == 8'h00 && !t2_irq_r && !t3_irq_r) else $error("outputs not cleared by reset");
  AST_UNMAPPED: assert property (!mapped |=> sfr_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  AST_PLAIN_RW: assert property (sfr_wr && plain ##1 !sfr_wr && sfr_addr == $past(sfr_addr)
    |=> sfr_rdata_r == $past(sfr_wdata, 2)) else $error("plain count byte lost its write");
  AST_T2_MASK: assert property (!t2_irq_enable && !$past(t2_irq_enable) |-> !t2_irq_r)
    else $error("second timer request while disabled");
  AST_T3_MASK: assert property (!t3_irq_enable && !$past(t3_irq_enable) |-> !t3_irq_r)
    else $error("third timer request while disabled");
  AST_T2_HOLD: assert property ($fell(t2_irq_r) |-> !t2_irq_enable || !$past(t2_irq_enable)
    || $past(c2w) || $past(c2w, 2) || $past(c2w, 3)) else $error("second timer flag cleared alone");
  AST_T3_HOLD: assert property ($fell(t3_irq_r) |-> !t3_irq_enable || !$past(t3_irq_enable)
    || $past(c3w) || $past(c3w, 2) || $past(c3w, 3)) else $error("third timer flag cleared alone");
  AST_T2_RISE: assert property ($rose(t2_irq_r) |-> t2_irq_enable || $past(t2_irq_enable))
    else $error("second timer request without enable");
endmodule

bind art_timers art_timers_chk u_chk
(
  .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .t2_irq_enable(t2_irq_enable),
  .t3_irq_enable(t3_irq_enable), .t2_irq_r(t2_irq_r), .t3_irq_r(t3_irq_r)
);

`default_nettype wire

// *** bench/tb.sv ***
// Self-checking testbench for the auto-reload and capture timers.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       clk       = 1'b0;
  logic       sys_rst   = 1'b1;
  logic [7:0] sfr_addr  = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic       sfr_wr    = 1'b0;
  logic       rd_v      = 1'b0;
  logic       rd_v_d    = 1'b0;
  logic [1:0] lsel      = 2'h0;
  logic [1:0] hsel      = 2'h0;
  logic [1:0] ien       = 2'h0;
  logic [3:0] ext       = 4'h0; // Oscillator, rtc, comparator one, comparator zero.
  logic [31:0] seed     = 32'hd0a92a2a;
  logic [7:0] exp_q[$];
  logic [7:0] adr_q[$];
  int         err_total = 0;
  int         comparisons = 0;
  wire [7:0]  sfr_rdata_r;
  wire        t2_irq_r;
  wire        t3_irq_r;
  logic [7:0] regs[11] = '{8'h8B, 8'h8C, 8'h8D, 8'h92, 8'h93, 8'h94, 8'h95,
                           8'hCA, 8'hCB, 8'hCC, 8'hCD};

  art_timers dut
  (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .t2_high_clock_select(hsel[0]), .t2_low_clock_select(lsel[0]),
    .t3_high_clock_select(hsel[1]), .t3_low_clock_select(lsel[1]),
    .t2_irq_enable(ien[0]), .t3_irq_enable(ien[1]),
    .comparator0(ext[0]), .comparator1(ext[1]), .rtc_div8(ext[2]),
    .external_oscillator_div8(ext[3]), .t2_irq_r(t2_irq_r), .t3_irq_r(t3_irq_r)
  );

  // 200 MHz system clock.
  always #2.5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Register k of timer t: control, reload low, reload high, count low, count high.
  function automatic logic [7:0] ra(input int t, input int k);
    ra = t ? 8'h91 + k[7:0] : (k == 0 ? 8'hC8 : 8'hC9 + k[7:0]);
  endfunction

  // Capture trigger and external clock of a source code, as input indices.
  function automatic int cp(input int t, input int s);
    cp = t ? (s < 2 ? 1 : 3) : (s < 2 ? 2 : 0);
  endfunction
  function automatic int ck(input int t, input int s);
    ck = t ? (s == 1 ? 3 : 1) : (s == 1 ? 0 : 2);
  endfunction

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Every bus cycle sets all request signals once, so no signal is assigned twice in a step.
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic v);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wr    <= w;
    sfr_wdata <= d;
    rd_v      <= v;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    bus(a, 1'b0, 8'h00, 1'b1);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(sfr_addr, 1'b0, 8'h00, 1'b0);
  endtask
  // A source pulse stays high and low long enough to pass the synchroniser.
  task automatic pulse(input int i);
    idle(1);
    ext[i] <= 1'b1;
    idle(4);
    ext[i] <= 1'b0;
    idle(4);
  endtask
  task automatic irqchk(input int t, input logic e);
    @(negedge clk);
    check(t ? "t3_irq" : "t2_irq", {7'h00, t ? t3_irq_r : t2_irq_r}, {7'h00, e});
  endtask

  task automatic results;
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Read data lands one edge after the address; the oldest note is taken off then.
  always @(posedge clk) rd_v_d <= rd_v;
  always @(negedge clk)
    if (rd_v_d)
      check($sformatf("reg_%h", adr_q.pop_front()), sfr_rdata_r, exp_q.pop_front());

  // Watchdog well beyond the few thousand cycles the sequence needs.
  initial
  begin
    #100000;
    err_total++;
    results;
  end

  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    rd(8'hC8, 8'h00);
    rd(8'h91, 8'h00);
    rd(8'h90, 8'h00);
    foreach (regs[i])
    begin
      seed = lfsr(seed);
      wr(regs[i], seed[7:0]);
      rd(regs[i], seed[7:0]);
    end
    for (int t = 0; t < 2; t++)
    begin
      lsel[t] <= 1'b1;
      ien[t]  <= 1'b1;
      wr(ra(t, 1), 8'h34);
      wr(ra(t, 2), 8'h12);
      wr(ra(t, 3), 8'hFE);
      wr(ra(t, 4), 8'hFF);
      wr(ra(t, 0), 8'h04);
      idle(8);
      rd(ra(t, 0), 8'hC4);
      rd(ra(t, 4), 8'h12);
      irqchk(t, 1'b1);
      idle(1);
      ien[t] <= 1'b0;
      idle(2);
      irqchk(t, 1'b0);
      idle(1);
      ien[t] <= 1'b1;
      wr(ra(t, 0), 8'h04);
      idle(3);
      irqchk(t, 1'b0);
      wr(ra(t, 0), 8'h24);
      idle(300);
      rd(ra(t, 0), 8'h64);
      irqchk(t, 1'b1);
      wr(ra(t, 0), 8'h04);
      idle(300);
      rd(ra(t, 0), 8'h44);
      irqchk(t, 1'b0);
      hsel[t] <= 1'b0;
      wr(ra(t, 1), 8'hF0);
      wr(ra(t, 3), 8'hF0);
      wr(ra(t, 4), 8'h77);
      wr(ra(t, 2), 8'hAB);
      wr(ra(t, 0), 8'h08);
      idle(40);
      rd(ra(t, 4), 8'h77);
      rd(ra(t, 0), 8'h48);
      wr(ra(t, 4), 8'hFF);
      wr(ra(t, 0), 8'h0D);
      pulse(ck(t, 1));
      rd(ra(t, 4), 8'hAB);
      pulse(ck(t, 1));
      rd(ra(t, 4), 8'hAC);
      rd(ra(t, 0), 8'hCD);
      lsel[t] <= 1'b0;
      wr(ra(t, 3), 8'h10);
      wr(ra(t, 0), 8'h07);
      pulse(ck(t, 1));
      pulse(ck(t, 3));
      pulse(ck(t, 3));
      rd(ra(t, 3), 8'h12);
      // Divided timebase: sixteen ticks need between 181 and 192 cycles.
      wr(ra(t, 3), 8'hF0);
      wr(ra(t, 4), 8'hFF);
      wr(ra(t, 0), 8'h04);
      idle(165);
      rd(ra(t, 0), 8'h04);
      idle(30);
      rd(ra(t, 0), 8'hC4);
      // High byte on the system clock in split mode steps once per cycle.
      hsel[t] <= 1'b1;
      wr(ra(t, 4), 8'h00);
      wr(ra(t, 0), 8'h0C);
      idle(20);
      rd(ra(t, 4), 8'h14);
      wr(ra(t, 0), 8'h00);
      lsel[t] <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
        wr(ra(t, 2), 8'h00);
        wr(ra(t, 3), 8'h00);
        wr(ra(t, 4), 8'h50 + s[7:0]);
        wr(ra(t, 0), 8'h14 | s[7:0]);
        pulse(cp(t, s ^ 2));
        rd(ra(t, 2), 8'h00);
        pulse(cp(t, s));
        rd(ra(t, 2), 8'h50 + s[7:0]);
        rd(ra(t, 0), 8'h94 | s[7:0]);
        irqchk(t, 1'b1);
        wr(ra(t, 0), 8'h00);
      end
    end
    idle(4);
    results;
  end
endmodule

`default_nettype wire
